/* src/osc_cal_pkg.sv */
// Purpose: Constants for the oscillator calibration counter
// Assumes: 16-bit register port, byte offsets as printed
// Notes: Status and mask offsets sit after the count words
package osc_cal_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SELECT     = 32'h5000_1600;
  localparam logic [ADDR_W-1:0] OFS_WINDOW     = 32'h5000_1602;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LO   = 32'h5000_1604;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HI   = 32'h5000_1606;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 32'h5000_1608;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 32'h5000_160A;

  // Select register fields
  localparam int SEL_LSB    = 0;
  localparam int SEL_W      = 2;
  localparam int START_BIT  = 2;
  localparam int EXTSEL_BIT = 3;

  // Reference codes
  localparam logic [1:0] REF_SLOW_RC    = 2'h0;
  localparam logic [1:0] REF_FAST_RC    = 2'h1;
  localparam logic [1:0] REF_SLOW_XTAL  = 2'h2;
  localparam logic [1:0] REF_LOW_FREQ_RC = 2'h3;

  // Input vector positions: four oscillators, external gate, fast clock
  localparam int N_OSC   = 4;
  localparam int EXT_POS = 4;
  localparam int FAST_POS = 5;
  localparam int N_IN    = 6;

  // Interrupt bits
  localparam int IRQ_W          = 2;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_REJECT_BIT = 1;

  // Reset values
  localparam logic [1:0]       RST_REF_SEL = 2'h0;
  localparam logic [15:0]      RST_WINDOW  = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_MASK    = 2'h0;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_ALIGN,
    CAL_RUN
  } cal_state_e;

endpackage

/* src/oscillator_calibration_counter.sv */
// Purpose: Measures a reference oscillator against the fast divided clock
// Assumes: Oscillators and fast clock arrive as pins, slower than clk/4
// Notes: Edges are found after a two-stage synchroniser on clk
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
module oscillator_calibration_counter
  import osc_cal_pkg::*;
#(
  parameter int WIN_W = 16,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  // Oscillator and gate pins
  input  wire logic [N_OSC-1:0]  osc_in,
  input  wire logic              ext_gate_in,
  input  wire logic              fast_clk_in,
  // Status
  output logic                   cal_busy,
  output logic                   irq
);

  logic [N_IN-1:0]   sync1_ff;
  logic [N_IN-1:0]   sync2_ff;
  logic [N_IN-1:0]   sync3_ff;
  logic [1:0]        ref_sel_ff;
  logic              ext_sel_ff;
  logic [WIN_W-1:0]  window_ff;
  logic [WIN_W-1:0]  down_ff;
  logic [CNT_W-1:0]  live_ff;
  logic [CNT_W-1:0]  result_ff;
  logic [IRQ_W-1:0]  status_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic              irq_ff;
  logic              busy_ff;
  cal_state_e        state_ff;
  cal_state_e        nxt_state;

  logic              wr_sel;
  logic              start_req;
  logic              ref_lvl;
  logic              ref_prev;
  logic              ref_edge;
  logic              fast_edge;
  logic              finish;
  logic [CNT_W-1:0]  nxt_live;
  logic [IRQ_W-1:0]  irq_set;
  logic [DATA_W-1:0] nxt_rd_data;

  assign rd_data  = rd_data_ff;
  assign irq      = irq_ff;
  assign cal_busy = busy_ff;

  // Pin synchroniser, third stage only for edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= {fast_clk_in, ext_gate_in, osc_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_comb begin
    if (ext_sel_ff) begin
      ref_lvl  = sync2_ff[EXT_POS];
      ref_prev = sync3_ff[EXT_POS];
    end else begin
      ref_lvl  = sync2_ff[ref_sel_ff];
      ref_prev = sync3_ff[ref_sel_ff];
    end
  end

  assign ref_edge  = ref_lvl & ~ref_prev;
  assign fast_edge = sync2_ff[FAST_POS] & ~sync3_ff[FAST_POS];

  assign wr_sel    = wr_en && (addr == OFS_SELECT);
  assign start_req = wr_sel && wr_data[START_BIT];
  // window ends on the edge at count one or zero
  assign finish    = (state_ff == CAL_RUN) && ref_edge && (down_ff <= WIN_W'(1));
  assign nxt_live  = live_ff + CNT_W'(fast_edge);

  // Configuration registers
  // Selection is frozen while a run is active to keep the window coherent
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_sel_ff <= RST_REF_SEL;
      ext_sel_ff <= 1'b0;
    end else if (wr_sel && state_ff == CAL_IDLE) begin
      ref_sel_ff <= wr_data[SEL_LSB +: SEL_W];
      ext_sel_ff <= wr_data[EXTSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      window_ff <= RST_WINDOW;
    end else if (wr_en && addr == OFS_WINDOW) begin
      window_ff <= wr_data[WIN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_ff <= RST_MASK;
    end else if (wr_en && addr == OFS_IRQ_MASK) begin
      mask_ff <= wr_data[IRQ_W-1:0];
    end
  end

  // Measurement sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CAL_IDLE: begin
        if (start_req) begin
          nxt_state = CAL_ALIGN;
        end
      end
      CAL_ALIGN: begin
        if (ref_edge) begin
          nxt_state = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (finish) begin
          nxt_state = CAL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= CAL_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != CAL_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      down_ff <= '0;
    end else if (state_ff == CAL_IDLE && start_req) begin
      down_ff <= window_ff;
    end else if (state_ff == CAL_RUN && ref_edge && !finish) begin
      down_ff <= down_ff - WIN_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      live_ff <= '0;
    end else if (state_ff == CAL_IDLE && start_req) begin
      live_ff <= '0;
    end else if (state_ff == CAL_RUN) begin
      live_ff <= nxt_live;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_ff <= '0;
    end else if (finish) begin
      result_ff <= nxt_live;
    end
  end

  // Interrupt status, set wins over read clear
  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_DONE_BIT]   = finish;
    irq_set[IRQ_REJECT_BIT] = start_req && (state_ff != CAL_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_ff <= '0;
    end else if (rd_en && addr == OFS_IRQ_STATUS) begin
      status_ff <= irq_set;
    end else begin
      status_ff <= status_ff | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // Read mux
  always_comb begin
    nxt_rd_data = '0;
    unique case (addr)
      OFS_SELECT: begin
        nxt_rd_data[SEL_LSB +: SEL_W] = ref_sel_ff;
        nxt_rd_data[START_BIT]        = busy_ff;
        nxt_rd_data[EXTSEL_BIT]       = ext_sel_ff;
      end
      OFS_WINDOW: begin
        nxt_rd_data[WIN_W-1:0] = window_ff;
      end
      OFS_COUNT_LO: begin
        nxt_rd_data = result_ff[DATA_W-1:0];
      end
      OFS_COUNT_HI: begin
        nxt_rd_data = result_ff[CNT_W-1:DATA_W];
      end
      OFS_IRQ_STATUS: begin
        nxt_rd_data[IRQ_W-1:0] = status_ff;
      end
      OFS_IRQ_MASK: begin
        nxt_rd_data[IRQ_W-1:0] = mask_ff;
      end
      default: begin
        nxt_rd_data = '0;
      end
    endcase
  end

  // Data valid only the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data_ff <= '0;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_start_launch: assert property (
    state_ff == CAL_IDLE && start_req |=> state_ff == CAL_ALIGN && down_ff == $past(window_ff)
  ) else $error("Start write did not launch a run");

  a_start_clears: assert property (
    state_ff == CAL_IDLE && !start_req ##1 (rd_en && addr == OFS_SELECT)
      |=> !rd_data[START_BIT]
  ) else $error("Start bit read back set while idle");

  a_busy_drop: assert property (
    finish |=> !busy_ff
  ) else $error("Busy still high after finish");

  a_done_flag: assert property (
    finish |=> status_ff[IRQ_DONE_BIT]
  ) else $error("Done flag missing after finish");

  a_sel_frozen: assert property (
    state_ff != CAL_IDLE |=> $stable(ref_sel_ff) && $stable(ext_sel_ff)
  ) else $error("Reference selection changed during run");

  a_ext_route: assert property (
    ext_sel_ff && state_ff == CAL_ALIGN && sync2_ff[EXT_POS] && !sync3_ff[EXT_POS]
      |=> state_ff == CAL_RUN
  ) else $error("External edge did not start window");

  a_window_step: assert property (
    state_ff == CAL_RUN && ref_edge && down_ff > WIN_W'(1) |=> down_ff == $past(down_ff) - 1'b1
  ) else $error("Window counter did not step");

  a_count_step: assert property (
    state_ff == CAL_RUN && fast_edge && !finish |=> live_ff == $past(live_ff) + 1'b1
  ) else $error("Fast edge not counted");

  a_high_word: assert property (
    rd_en && addr == OFS_COUNT_HI |=> rd_data == $past(result_ff[CNT_W-1:DATA_W])
  ) else $error("High result word wrong");

  a_low_word: assert property (
    rd_en && addr == OFS_COUNT_LO |=> rd_data == $past(result_ff[DATA_W-1:0])
  ) else $error("Low result word wrong");

  a_result_hold: assert property (
    !finish |=> $stable(result_ff)
  ) else $error("Result moved outside finish");

  a_restart_flag: assert property (
    state_ff == CAL_RUN && start_req && !finish |=> state_ff == CAL_RUN && status_ff[IRQ_REJECT_BIT]
  ) else $error("Restart during run not rejected");

  a_align_restart: assert property (
    state_ff == CAL_ALIGN && start_req && !ref_edge |=> state_ff == CAL_ALIGN && $stable(down_ff)
  ) else $error("Restart while aligning disturbed the run");

  a_ref_select: assert property (
    !ext_sel_ff && state_ff == CAL_ALIGN && sync2_ff[ref_sel_ff] && !sync3_ff[ref_sel_ff]
      |=> state_ff == CAL_RUN
  ) else $error("Selected reference edge did not start window");

  a_window_hold: assert property (
    state_ff == CAL_RUN && !ref_edge |=> $stable(down_ff)
  ) else $error("Window counter moved without reference edge");

  a_count_idle: assert property (
    state_ff != CAL_RUN && !start_req |=> $stable(live_ff)
  ) else $error("Fast counter moved outside the window");

  a_result_load: assert property (
    finish |=> result_ff == live_ff
  ) else $error("Result differs from final count");

  // Interrupt follows masked status one cycle later
  a_irq_raise: assert property (
    |(status_ff & mask_ff) |=> irq
  ) else $error("Interrupt missing for unmasked status");

  a_irq_drop: assert property (
    !(|(status_ff & mask_ff)) |=> !irq
  ) else $error("Interrupt high without unmasked status");

  a_rdata_idle: assert property (
    !rd_en |=> rd_data == DATA_W'(0)
  ) else $error("Read data not zero outside read slot");

  a_status_clear: assert property (
    rd_en && addr == OFS_IRQ_STATUS && irq_set == '0 |=> status_ff == '0
  ) else $error("Status not cleared by read");

  c_full_run: cover property (state_ff == CAL_RUN ##[1:1000] finish);
  c_rejected: cover property (status_ff[IRQ_REJECT_BIT]);
  c_irq_seen: cover property (irq_ff && mask_ff[IRQ_DONE_BIT]);
  c_ext_mode: cover property (ext_sel_ff && finish);
  c_align_restart: cover property (state_ff == CAL_ALIGN && start_req);

endmodule

/* sim/tb_oscillator_calibration_counter.sv */
// Purpose: Self-checking bench for the oscillator calibration counter
// Assumes: Pin waves derived from clk; reference 24, others 12, gate 36, fast 6 clk
// Notes: Fast edges never coincide with reference edges, so counts are exact
`timescale 1ns/1ns
module tb_oscillator_calibration_counter;
  import osc_cal_pkg::*;
  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [N_OSC-1:0]  osc_in;
  logic              ext_gate_in;
  logic              fast_clk_in;
  logic              cal_busy;
  logic              irq;
  logic [1:0]        cur_sel;
  logic [IRQ_W-1:0]  cur_mask;
  logic [15:0]       prev_res;
  int                tick;
  int                failures;
  int                cmp_count;
  int                seed;

  oscillator_calibration_counter i_dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .osc_in(osc_in), .ext_gate_in(ext_gate_in),
    .fast_clk_in(fast_clk_in), .cal_busy(cal_busy), .irq(irq)
  );

  always #5 clk = ~clk;

  // Unselected pins run at another rate so a wrong pick shows in the count
  always @(posedge clk) begin
    tick <= tick + 1;
    for (int i = 0; i < N_OSC; i++) begin
      osc_in[i] <= (i == cur_sel) ? (tick % 24 < 12) : (tick % 12 < 6);
    end
    ext_gate_in <= (tick % 36 < 18);
    fast_clk_in <= ((tick + 5) % 6 < 3);
  end

  function automatic logic [15:0] exp_count(logic ext, logic [15:0] n);
    logic [15:0] w;
    w = (n == 16'h0000) ? 16'h0001 : n;
    return ext ? 16'(w * 6) : 16'(w * 4);
  endfunction

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(string name, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(name, {16'h0000, rd_data}, {16'h0000, exp});
  endtask

  task automatic run(logic [1:0] sel, logic ext, logic [15:0] n, logic restart);
    logic [15:0] sel_word;
    int          k;
    cur_sel = sel;
    sel_word = {12'h000, ext, 1'b1, sel};
    wr(OFS_WINDOW, n);
    rd_chk("window", OFS_WINDOW, n);
    wr(OFS_SELECT, sel_word);
    rd_chk("start readback", OFS_SELECT, sel_word);
    chk("busy", {31'h0, cal_busy}, 32'h0000_0001);
    // Restart with other fields must leave the run untouched
    if (restart) wr(OFS_SELECT, sel_word ^ 16'h000b);
    rd_chk("result held", OFS_COUNT_LO, prev_res);
    k = 0;
    while (cal_busy === 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 2000) begin
      failures++;
      print_verdict();
    end
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, {31'h0, cur_mask[0] | (cur_mask[1] & restart)});
    rd_chk("status", OFS_IRQ_STATUS, {14'h0000, restart, 1'b1});
    @(posedge clk);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd_chk("start cleared", OFS_SELECT, {12'h000, ext, 1'b0, sel});
    rd_chk("count low", OFS_COUNT_LO, exp_count(ext, n));
    rd_chk("count high", OFS_COUNT_HI, 16'h0000);
    prev_res = exp_count(ext, n);
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    osc_in = '0;
    ext_gate_in = 1'b0;
    fast_clk_in = 1'b0;
    cur_sel = 2'h0;
    cur_mask = '0;
    prev_res = 16'h0000;
    tick = 0;
    failures = 0;
    cmp_count = 0;
    seed = $urandom(32'ha470_e0fa);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("select reset", OFS_SELECT, 16'h0000);
    rd_chk("window reset", OFS_WINDOW, 16'h0000);
    rd_chk("low reset", OFS_COUNT_LO, 16'h0000);
    rd_chk("high reset", OFS_COUNT_HI, 16'h0000);
    rd_chk("mask reset", OFS_IRQ_MASK, 16'h0000);
    wr(OFS_COUNT_LO, 16'hffff);
    rd_chk("low read only", OFS_COUNT_LO, 16'h0000);
    wr(32'h5000_1610, 16'h1234);
    rd_chk("unmapped", 32'h5000_1610, 16'h0000);
    // Every select code in both gate modes, then random picks
    for (int i = 0; i < 14; i++) begin
      cur_mask = 2'($urandom % 4);
      wr(OFS_IRQ_MASK, {14'h0000, cur_mask});
      rd_chk("mask", OFS_IRQ_MASK, {14'h0000, cur_mask});
      if (i < 8) begin
        run(2'(i % 4), i[2], (i < 2) ? 16'(i) : 16'($urandom_range(2, 20)), i[0]);
      end else begin
        run(2'($urandom % 4), 1'($urandom % 2), 16'($urandom_range(1, 20)), 1'($urandom % 2));
      end
    end
    print_verdict();
  end
endmodule
